// *** hw/fps_follower_sync.sv ***
// Follower axis position bookkeeping with an AHB-Lite register slave.
// Assumes pins EDGE_IN, HOME_SW, MASTER_STEP and MASTER_DIR are asynchronous,
// POS_ERROR comes from the servo loop on CLK, and the bus is zero-wait.
`timescale 1ns/1ns

module fps_follower_sync #(
  parameter int unsigned SERVO_CYCLES = fps_pkg::SERVO_CYCLES_DEF
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [15:0] EDGE_IN,
  input  wire logic        HOME_SW,
  input  wire logic        MASTER_STEP,
  input  wire logic        MASTER_DIR,
  input  wire logic [31:0] POS_ERROR,
  output logic             IRQ,
  output logic             MOVING,
  output logic             FOLLOWER_ACTIVE,
  output logic             POSITION_VALID
);

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction : abs32

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  localparam int IRQ_W_L = fps_pkg::IRQ_W - 1;

  logic [15:0]       edge_s1_reg, edge_s2_reg, edge_s3_reg;
  logic [2:0]        home_sync_reg;
  logic [2:0]        mstep_sync_reg;
  logic [1:0]        mdir_sync_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_addr_reg;
  logic [31:0]       hrdata_reg;
  logic [31:0]       ctrl_reg;
  logic [1:0]        select_reg;
  logic [15:0]       vel_reg;
  logic [31:0]       home_val_reg;
  logic [4:0]        edge_cfg_reg;
  logic [31:0]       act_pos_reg, pos_err_reg, prog_pos_reg, trig_pos_reg, remain_reg;
  logic [7:0]        err_code_reg;
  logic [IRQ_W_L:0]  irq_stat_reg, irq_en_reg;
  logic              follow_reg, pos_valid_reg, prog_run_reg;
  logic [31:0]       tick_cnt_reg;
  logic [15:0]       master_acc_reg;
  fps_pkg::fps_mode_t mode_reg;

  logic              tick, wr_ctrl, wr_setpos, wr_dist, wr_clr;
  logic              cmd_home, cmd_exec, cmd_cont, abort_all, en_follow;
  logic              setpos_ok, setpos_bad, home_bad, home_done, move_done, trip;
  logic              edge_now, edge_old, home_rise, mstep_rise;
  logic [31:0]       step, cmd_pos, master_apply;
  logic [15:0]       master_next;
  logic [IRQ_W_L:0]  irq_ev;

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      edge_s1_reg    <= 16'h0000;
      edge_s2_reg    <= 16'h0000;
      edge_s3_reg    <= 16'h0000;
      home_sync_reg  <= 3'h0;
      mstep_sync_reg <= 3'h0;
      mdir_sync_reg  <= 2'h0;
    end
    else
    begin
      edge_s1_reg    <= EDGE_IN;
      edge_s2_reg    <= edge_s1_reg;
      edge_s3_reg    <= edge_s2_reg;
      home_sync_reg  <= {home_sync_reg[1:0], HOME_SW};
      mstep_sync_reg <= {mstep_sync_reg[1:0], MASTER_STEP};
      mdir_sync_reg  <= {mdir_sync_reg[0], MASTER_DIR};
    end
  end

  assign edge_now   = edge_s2_reg[edge_cfg_reg[3:0]] ^ edge_cfg_reg[4];
  assign edge_old   = edge_s3_reg[edge_cfg_reg[3:0]] ^ edge_cfg_reg[4];
  assign home_rise  = home_sync_reg[1] & ~home_sync_reg[2];
  assign mstep_rise = mstep_sync_reg[1] & ~mstep_sync_reg[2];

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY, read data registered.
  // ----------------------------------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_reg;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= HSEL & HTRANS[1] & HREADY & HWRITE;
      wr_addr_reg <= HADDR[7:0];
    end
  end

  // Reads decode in the address phase so data stands from a flop in the data phase.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      hrdata_reg <= fps_pkg::RST_WORD;
    else if (HSEL & HTRANS[1] & HREADY & ~HWRITE)
    begin
      case (HADDR[7:0])
        fps_pkg::OFF_CTRL:      hrdata_reg <= ctrl_reg;
        fps_pkg::OFF_SELECT:    hrdata_reg <= {30'h0, select_reg};
        fps_pkg::OFF_MOVE_VEL:  hrdata_reg <= {16'h0000, vel_reg};
        fps_pkg::OFF_HOME_VAL:  hrdata_reg <= home_val_reg;
        fps_pkg::OFF_EDGE_CFG:  hrdata_reg <= {27'h0, edge_cfg_reg};
        fps_pkg::OFF_STATUS:    hrdata_reg <= {28'h0, prog_run_reg, pos_valid_reg,
                                               follow_reg, MOVING};
        fps_pkg::OFF_ACT_POS:   hrdata_reg <= act_pos_reg;
        fps_pkg::OFF_POS_ERR:   hrdata_reg <= pos_err_reg;
        fps_pkg::OFF_PROG_POS:  hrdata_reg <= prog_pos_reg;
        fps_pkg::OFF_USER_DATA:
        begin
          case (select_reg)
            2'd0:    hrdata_reg <= act_pos_reg;
            2'd1:    hrdata_reg <= pos_err_reg;
            2'd2:    hrdata_reg <= prog_pos_reg;
            default: hrdata_reg <= cmd_pos;
          endcase
        end
        fps_pkg::OFF_TRIG_POS:  hrdata_reg <= trig_pos_reg;
        fps_pkg::OFF_IRQ_STAT:  hrdata_reg <= {28'h0, irq_stat_reg};
        fps_pkg::OFF_IRQ_EN:    hrdata_reg <= {28'h0, irq_en_reg};
        fps_pkg::OFF_ERR_CODE:  hrdata_reg <= {24'h0, err_code_reg};
        default:                hrdata_reg <= fps_pkg::RST_WORD;
      endcase
    end
  end

  assign wr_ctrl   = wr_pend_reg & (wr_addr_reg == fps_pkg::OFF_CTRL);
  assign wr_setpos = wr_pend_reg & (wr_addr_reg == fps_pkg::OFF_SET_POS);
  assign wr_dist   = wr_pend_reg & (wr_addr_reg == fps_pkg::OFF_MOVE_DIST);
  assign wr_clr    = wr_pend_reg & (wr_addr_reg == fps_pkg::OFF_IRQ_CLR);

  // Command bits act as one-shot pulses on a control write; level bits are stored.
  assign cmd_home  = wr_ctrl & HWDATA[fps_pkg::CTRL_FIND_HOME];
  assign cmd_exec  = wr_ctrl & HWDATA[fps_pkg::CTRL_EXEC_PROGRAM];
  assign cmd_cont  = wr_ctrl & HWDATA[fps_pkg::CTRL_CONT_MOVE];
  assign en_follow = ctrl_reg[fps_pkg::CTRL_ENABLE_FOLLOWER];
  assign abort_all = ctrl_reg[fps_pkg::CTRL_ABORT_ALL];

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_reg     <= fps_pkg::RST_WORD;
      select_reg   <= 2'd0;
      vel_reg      <= 16'h0000;
      home_val_reg <= fps_pkg::RST_WORD;
      edge_cfg_reg <= 5'h00;
      irq_en_reg   <= '0;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        fps_pkg::OFF_CTRL:     ctrl_reg     <= {29'h0, HWDATA[2:0]};
        fps_pkg::OFF_SELECT:   select_reg   <= HWDATA[1:0];
        fps_pkg::OFF_MOVE_VEL: vel_reg      <= HWDATA[15:0];
        fps_pkg::OFF_HOME_VAL: home_val_reg <= HWDATA;
        fps_pkg::OFF_EDGE_CFG: edge_cfg_reg <= HWDATA[4:0];
        fps_pkg::OFF_IRQ_EN:   irq_en_reg   <= HWDATA[IRQ_W_L:0];
        default:               ctrl_reg     <= ctrl_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Servo update tick.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      tick_cnt_reg <= 32'h0000_0000;
    else if (tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end

  assign tick = (tick_cnt_reg == 32'(SERVO_CYCLES - 1));

  // ----------------------------------------------------------------
  // Internal move generator.
  // ----------------------------------------------------------------
  always_comb
  begin
    case (mode_reg)
      fps_pkg::FPS_POS_MOVE:
        if (abs32(remain_reg) <= abs32(sext16(vel_reg)))
          step = remain_reg;
        else
          step = remain_reg[31] ? 32'(-abs32(sext16(vel_reg))) : abs32(sext16(vel_reg));
      fps_pkg::FPS_CONT_MOVE, fps_pkg::FPS_HOME:
        step = sext16(vel_reg);
      default:
        step = 32'h0000_0000;
    endcase
  end

  assign MOVING     = (mode_reg != fps_pkg::FPS_IDLE);
  assign cmd_pos    = act_pos_reg + pos_err_reg;
  assign home_bad   = cmd_home & en_follow;
  assign setpos_ok  = wr_setpos & ~MOVING;
  assign setpos_bad = wr_setpos & MOVING;
  assign home_done  = (mode_reg == fps_pkg::FPS_HOME) & home_rise & ~abort_all;
  assign move_done  = tick & (mode_reg == fps_pkg::FPS_POS_MOVE) & (remain_reg == step);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_reg   <= fps_pkg::FPS_IDLE;
      remain_reg <= fps_pkg::RST_WORD;
    end
    else if (abort_all)
      mode_reg   <= fps_pkg::FPS_IDLE;
    else if (cmd_home & ~en_follow)
      mode_reg   <= fps_pkg::FPS_HOME;
    else if (wr_dist)
    begin
      mode_reg   <= fps_pkg::FPS_POS_MOVE;
      remain_reg <= HWDATA;
    end
    else if (cmd_cont)
      mode_reg   <= fps_pkg::FPS_CONT_MOVE;
    else if (home_done | move_done)
      mode_reg   <= fps_pkg::FPS_IDLE;
    else if (tick & (mode_reg == fps_pkg::FPS_POS_MOVE))
      remain_reg <= remain_reg - step;
  end

  // ----------------------------------------------------------------
  // Follower engagement and master count accumulation.
  // ----------------------------------------------------------------
  assign trip = en_follow & ~follow_reg & edge_now & ~edge_old;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      follow_reg   <= 1'b0;
      trig_pos_reg <= fps_pkg::RST_WORD;
    end
    else if (!en_follow)
      follow_reg   <= 1'b0;
    else if (trip)
    begin
      follow_reg   <= 1'b1;
      trig_pos_reg <= cmd_pos;
    end
  end

  // The ramp limits master counts applied per tick; the backlog is carried so
  // the follower catches up; counts applied on a tick taken over by a synchronising load are lost.
  always_comb
  begin
    master_apply = sext16(master_acc_reg);
    if (ctrl_reg[fps_pkg::CTRL_RAMP_EN])
    begin
      if (master_acc_reg[15] & (abs32(sext16(master_acc_reg)) > 32'(fps_pkg::RAMP_MAX_STEP)))
        master_apply = 32'(-sext16(fps_pkg::RAMP_MAX_STEP));
      else if (!master_acc_reg[15] && master_acc_reg > fps_pkg::RAMP_MAX_STEP)
        master_apply = sext16(fps_pkg::RAMP_MAX_STEP);
    end
    master_next = master_acc_reg - (tick ? master_apply[15:0] : 16'h0000);
    if (mstep_rise)
      master_next = mdir_sync_reg[1] ? master_next - 16'h0001 : master_next + 16'h0001;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      master_acc_reg <= 16'h0000;
    else if (!follow_reg)
      master_acc_reg <= 16'h0000;
    else
      master_acc_reg <= master_next;
  end

  // ----------------------------------------------------------------
  // Position registers. Synchronising loads take precedence over a tick.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      act_pos_reg  <= fps_pkg::RST_WORD;
      pos_err_reg  <= fps_pkg::RST_WORD;
      prog_pos_reg <= fps_pkg::RST_WORD;
    end
    else if (setpos_ok)
    begin
      act_pos_reg  <= HWDATA;
      prog_pos_reg <= HWDATA + pos_err_reg;
    end
    else if (home_done)
    begin
      act_pos_reg  <= home_val_reg;
      prog_pos_reg <= home_val_reg + pos_err_reg;
    end
    else if (cmd_exec)
      prog_pos_reg <= en_follow ? fps_pkg::PROG_REF_POS : cmd_pos;
    else if (tick)
    begin
      // Master counts reach only actual position; the 32-bit adder wraps.
      act_pos_reg  <= act_pos_reg + step + (follow_reg ? master_apply : 32'h0);
      pos_err_reg  <= POS_ERROR;
      prog_pos_reg <= prog_pos_reg + step;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and errors.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pos_valid_reg <= 1'b0;
      prog_run_reg  <= 1'b0;
      err_code_reg  <= fps_pkg::ERR_NONE;
    end
    else
    begin
      if (home_done)
        pos_valid_reg <= 1'b1;
      if (cmd_exec)
        prog_run_reg  <= 1'b1;
      else if (abort_all | ~en_follow & follow_reg)
        prog_run_reg  <= 1'b0;
      if (home_bad)
        err_code_reg  <= fps_pkg::ERR_HOME_FOLLOW;
      else if (setpos_bad)
        err_code_reg  <= fps_pkg::ERR_SETPOS_MOVE;
    end
  end

  assign FOLLOWER_ACTIVE = follow_reg;
  assign POSITION_VALID  = pos_valid_reg;

  // ----------------------------------------------------------------
  // Interrupts: a new event wins over a clear in the same cycle.
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_ev = '0;
    irq_ev[fps_pkg::IRQ_HOME_DONE] = home_done;
    irq_ev[fps_pkg::IRQ_TRIP]      = trip;
    irq_ev[fps_pkg::IRQ_ERROR]     = home_bad | setpos_bad;
    irq_ev[fps_pkg::IRQ_MOVE_DONE] = move_done;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? HWDATA[IRQ_W_L:0] : '0)) | irq_ev;
  end

  assign IRQ = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  chk_home_reject: assert property (@(posedge CLK) disable iff (!RST_N)
    home_bad |=> err_code_reg == fps_pkg::ERR_HOME_FOLLOW && mode_reg != fps_pkg::FPS_HOME)
    else $error("homing accepted while following");
  chk_setpos_load: assert property (@(posedge CLK) disable iff (!RST_N)
    setpos_ok |=> act_pos_reg == $past(HWDATA) && prog_pos_reg == act_pos_reg + pos_err_reg)
    else $error("set position did not synchronise");
  chk_setpos_refuse: assert property (@(posedge CLK) disable iff (!RST_N)
    setpos_bad |=> err_code_reg == fps_pkg::ERR_SETPOS_MOVE)
    else $error("set position while moving not refused");
  chk_exec_plain: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_exec && !en_follow && !setpos_ok && !home_done
      |=> prog_pos_reg == $past(act_pos_reg) + $past(pos_err_reg))
    else $error("program start did not sync program position");
  chk_exec_follow: assert property (@(posedge CLK) disable iff (!RST_N)
    cmd_exec && en_follow && !setpos_ok && !home_done |=> prog_pos_reg == fps_pkg::PROG_REF_POS)
    else $error("program start while following not zero");
  chk_abort_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    abort_all |=> !MOVING [*2])
    else $error("move survived abort");
  chk_trip_save: assert property (@(posedge CLK) disable iff (!RST_N)
    trip |=> follow_reg && trig_pos_reg == $past(cmd_pos))
    else $error("trigger did not engage or save position");
  chk_valid_home: assert property (@(posedge CLK) disable iff (!RST_N)
    home_done |=> POSITION_VALID && act_pos_reg == $past(home_val_reg))
    else $error("homing did not validate position");
  chk_master_only: assert property (@(posedge CLK) disable iff (!RST_N)
    tick && !MOVING && !setpos_ok && !home_done && !cmd_exec |=> $stable(prog_pos_reg))
    else $error("master counts moved program position");

  cov_home_done:   cover property (@(posedge CLK) disable iff (!RST_N) home_done);
  cov_trip:        cover property (@(posedge CLK) disable iff (!RST_N) trip ##[1:1000] cmd_exec);
  cov_setpos_bad:  cover property (@(posedge CLK) disable iff (!RST_N) setpos_bad);
  cov_move_done:   cover property (@(posedge CLK) disable iff (!RST_N) move_done);

endmodule : fps_follower_sync

// *** pkg/fps_pkg.sv ***
// Constants for the follower position bookkeeping block.
// Assumes one clock domain at 20 MHz and an AHB-Lite register bus.
package fps_pkg;

  // --------------------------------------------------------------
  // Register byte offsets.
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_SET_POS   = 8'h04;
  localparam logic [7:0] OFF_SELECT    = 8'h08;
  localparam logic [7:0] OFF_MOVE_DIST = 8'h0C;
  localparam logic [7:0] OFF_MOVE_VEL  = 8'h10;
  localparam logic [7:0] OFF_HOME_VAL  = 8'h14;
  localparam logic [7:0] OFF_EDGE_CFG  = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;
  localparam logic [7:0] OFF_ACT_POS   = 8'h20;
  localparam logic [7:0] OFF_POS_ERR   = 8'h24;
  localparam logic [7:0] OFF_PROG_POS  = 8'h28;
  localparam logic [7:0] OFF_USER_DATA = 8'h2C;
  localparam logic [7:0] OFF_TRIG_POS  = 8'h30;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h34;
  localparam logic [7:0] OFF_IRQ_CLR   = 8'h38;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h3C;
  localparam logic [7:0] OFF_ERR_CODE  = 8'h40;

  // --------------------------------------------------------------
  // Control register fields.
  // --------------------------------------------------------------
  localparam int CTRL_ENABLE_FOLLOWER = 0;
  localparam int CTRL_RAMP_EN         = 1;
  localparam int CTRL_ABORT_ALL       = 2;
  localparam int CTRL_FIND_HOME       = 4;
  localparam int CTRL_EXEC_PROGRAM    = 5;
  localparam int CTRL_CONT_MOVE       = 6;

  // Status register fields.
  localparam int ST_MOVING        = 0;
  localparam int ST_FOLLOWER_ACT  = 1;
  localparam int ST_POS_VALID     = 2;
  localparam int ST_PROG_RUN      = 3;

  // Interrupt event bits.
  localparam int IRQ_HOME_DONE = 0;
  localparam int IRQ_TRIP      = 1;
  localparam int IRQ_ERROR     = 2;
  localparam int IRQ_MOVE_DONE = 3;
  localparam int IRQ_W         = 4;

  // --------------------------------------------------------------
  // Error codes and reset values.
  // --------------------------------------------------------------
  localparam logic [7:0]  ERR_NONE        = 8'h00;
  localparam logic [7:0]  ERR_HOME_FOLLOW = 8'h01;
  localparam logic [7:0]  ERR_SETPOS_MOVE = 8'h02;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [31:0] PROG_REF_POS    = 32'h0000_0000;
  localparam logic [15:0] RAMP_MAX_STEP   = 16'h0004;

  // --------------------------------------------------------------
  // Servo update timing.
  // --------------------------------------------------------------
  localparam int CLK_FREQ_HZ        = 20_000_000;
  localparam int SERVO_PERIOD_US    = 2000;
  localparam int SERVO_CYCLES_DEF   = CLK_FREQ_HZ / 1_000_000 * SERVO_PERIOD_US;

  typedef enum logic [1:0]
  {
    FPS_IDLE = 2'b00,
    FPS_POS_MOVE = 2'b01,
    FPS_CONT_MOVE = 2'b10,
    FPS_HOME = 2'b11
  } fps_mode_t;

endpackage : fps_pkg

// *** tb/fps_field_model.sv ***
// Field side of the axis: home switch, part sensor, master encoder and servo error.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/1ns
module fps_field_model (
  input  wire logic        clk,
  output logic      [15:0] edge_in,
  output logic             home_sw,
  output logic             step,
  output logic             dir,
  output logic      [31:0] pos_err
);
  initial
  begin
    edge_in = 16'h0000;
    home_sw = 1'b0;
    step = 1'b0;
    dir = 1'b0;
    pos_err = 32'h0000_0005;
  end

  // Home and trip pulses last four clocks, master steps three, so the pin synchronisers cannot miss them.
  task hit_home();
    home_sw <= 1'b1;
    repeat (4) @(posedge clk);
    home_sw <= 1'b0;
  endtask : hit_home

  task trip(input int i);
    edge_in[i] <= 1'b1;
    repeat (4) @(posedge clk);
    edge_in[i] <= 1'b0;
  endtask : trip

  task master(input int n);
    repeat (n)
    begin
      step <= 1'b1;
      repeat (3) @(posedge clk);
      step <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : master
endmodule : fps_field_model

// *** tb/test_follower_position_sync.sv ***
// Self-checking bench for the follower position block over AHB-Lite.
// Assumes a zero-wait slave and a servo tick every eight clocks.
`timescale 1ns/1ns
module test_follower_position_sync;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        irq, moving, f_act, p_val, hresp;
  logic [15:0] edge_in;
  logic        home_sw, step, dir;
  logic [31:0] pos_err, a, v;
  int          err_count = 0;
  int          n_checks = 0;

  always #25 clk = ~clk;

  fps_follower_sync #(.SERVO_CYCLES(8)) dut_u (.CLK(clk), .RST_N(rst_n), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .EDGE_IN(edge_in),
    .HOME_SW(home_sw), .MASTER_STEP(step), .MASTER_DIR(dir), .POS_ERROR(pos_err),
    .IRQ(irq), .MOVING(moving), .FOLLOWER_ACTIVE(f_act), .POSITION_VALID(p_val));
  fps_field_model field_u (.clk(clk), .edge_in(edge_in), .home_sw(home_sw),
    .step(step), .dir(dir), .pos_err(pos_err));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Address phase is held until hready, then the data phase likewise.
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, ad};
    hwrite <= w;
    cyc(1);
    while (hready !== 1'b1) cyc(1);
    htrans <= 2'h0;
    hwdata <= wd;
    cyc(1);
    while (hready !== 1'b1) cyc(1);
    v = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask : wr

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0000_0000);
    check(v, exp);
  endtask : rdchk

  task automatic t_home();
    wr(fps_pkg::OFF_IRQ_EN, 32'h0000_0001);
    wr(fps_pkg::OFF_MOVE_VEL, 32'h0000_0001);
    wr(fps_pkg::OFF_HOME_VAL, 32'h0000_1234);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0010);
    cyc(20);
    field_u.hit_home();
    cyc(4);
    rdchk(fps_pkg::OFF_ACT_POS, 32'h0000_1234);
    rdchk(fps_pkg::OFF_PROG_POS, 32'h0000_1239);
    check({31'h0, p_val}, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    wr(fps_pkg::OFF_IRQ_CLR, 32'h0000_000F);
    cyc(1);
    check({31'h0, irq}, 32'h0000_0000);
  endtask : t_home

  task automatic t_setpos_wrap();
    wr(fps_pkg::OFF_SET_POS, 32'h7FFF_FFF0);
    rdchk(fps_pkg::OFF_ACT_POS, 32'h7FFF_FFF0);
    rdchk(fps_pkg::OFF_PROG_POS, 32'h7FFF_FFF5);
    wr(fps_pkg::OFF_MOVE_VEL, 32'h0000_0010);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0040);
    cyc(32);
    check({31'h0, moving}, 32'h0000_0001);
    wr(fps_pkg::OFF_SET_POS, 32'h0000_0000);
    rdchk(fps_pkg::OFF_ERR_CODE, 32'h0000_0002);
    bus(1'b0, fps_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    check({29'h0, v[2], 1'b0, irq}, 32'h0000_0004);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0004);
    cyc(2);
    check({31'h0, moving}, 32'h0000_0000);
    bus(1'b0, fps_pkg::OFF_ACT_POS, 32'h0000_0000);
    a = v;
    rdchk(fps_pkg::OFF_PROG_POS, a + 32'h0000_0005);
    check({31'h0, v[31]}, 32'h0000_0001);
  endtask : t_setpos_wrap

  task automatic t_follow();
    wr(fps_pkg::OFF_MOVE_VEL, 32'h0000_0000);
    wr(fps_pkg::OFF_EDGE_CFG, 32'h0000_0003);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0003);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0013);
    rdchk(fps_pkg::OFF_ERR_CODE, 32'h0000_0001);
    check({31'h0, moving}, 32'h0000_0000);
    field_u.trip(3);
    cyc(2);
    check({31'h0, f_act}, 32'h0000_0001);
    rdchk(fps_pkg::OFF_TRIG_POS, a + 32'h0000_0005);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0023);
    rdchk(fps_pkg::OFF_PROG_POS, fps_pkg::PROG_REF_POS);
    field_u.master(10);
    cyc(10);
    rdchk(fps_pkg::OFF_ACT_POS, a + 32'h0000_000A);
    rdchk(fps_pkg::OFF_PROG_POS, fps_pkg::PROG_REF_POS);
    wr(fps_pkg::OFF_CTRL, 32'h0000_0004);
    cyc(2);
    check({31'h0, f_act}, 32'h0000_0000);
  endtask : t_follow

  task automatic t_exec_select();
    bus(1'b0, fps_pkg::OFF_ACT_POS, 32'h0000_0000);
    a = v;
    wr(fps_pkg::OFF_CTRL, 32'h0000_0020);
    rdchk(fps_pkg::OFF_ACT_POS, a);
    rdchk(fps_pkg::OFF_PROG_POS, a + 32'h0000_0005);
    wr(fps_pkg::OFF_SELECT, 32'h0000_0002);
    rdchk(fps_pkg::OFF_USER_DATA, a + 32'h0000_0005);
    rdchk(fps_pkg::OFF_STATUS, 32'h0000_000C);
    check({31'h0, hresp}, 32'h0000_0000);
    wr(fps_pkg::OFF_MOVE_VEL, 32'h0000_0003);
    wr(fps_pkg::OFF_MOVE_DIST, 32'h0000_0007);
    cyc(40);
    rdchk(fps_pkg::OFF_ACT_POS, a + 32'h0000_0007);
    rdchk(fps_pkg::OFF_PROG_POS, a + 32'h0000_000C);
    bus(1'b0, fps_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    check({28'h0, v[3:0]}, 32'h0000_000E);
    rdchk(8'h80, 32'h0000_0000);
  endtask : t_exec_select

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
    t_home();
    t_setpos_wrap();
    t_follow();
    t_exec_select();
    summarize();
  end

  // A hang costs one mismatch and still ends through the verdict.
  initial
  begin
    cyc(6000);
    err_count++;
    summarize();
  end
endmodule : test_follower_position_sync
